// File: inc/snpc_pkg.sv
// package for the scan port network configuration block
// assumes one backplane test clock drives all logic that includes it
package snpc_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int PORT_COUNT = 3;
	localparam int FIFO_DEPTH = 16;

	// ------------------------------------------------------------
	// reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] MODE_ZERO_RESET = 8'h01;
	localparam logic [7:0] MODE_ONE_RESET = 8'h00;
	localparam logic [1:0] GROUP_RESET = 2'h0;
	localparam logic [7:0] GROUP_BASE_ADDR = 8'h3c;
	localparam logic [7:0] GROUP_ADDR_MASK = 8'hfc;
	localparam int MODE_PORT_LSB = 0;
	localparam int MODE_CLK_STOP_BIT = 3;
	localparam int MODE_LOOPBACK_BIT = 4;
	localparam int MODE_STATUS_BIT = 7;
	// writable bits of the first mode register on three-port silicon
	localparam logic [7:0] MODE_ZERO_WMASK = 8'h1f;
	// writable bits of the second mode register (none used here)
	localparam logic [7:0] MODE_ONE_WMASK = 8'hff;

	// ------------------------------------------------------------
	// counts of backplane clock cycles
	// ------------------------------------------------------------
	localparam logic [9:0] RESET_PARK_CYCLES = 10'd512;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SNPC_UNPARKED,
		SNPC_PARKED_IN_RESET,
		SNPC_PARKED_IN_IDLE,
		SNPC_PARKED_IN_PAUSE
	} snpc_park_type;

	// data-register phase strobes from the test controller
	typedef struct packed {
		logic capture;
		logic shift;
		logic update;
	} snpc_dr_type;

	// decoded data-register selects
	typedef struct packed {
		logic mode_select_instr;
		logic mode_one_select;
		logic group_select;
	} snpc_instr_type;

	// one routing change handed to the local port sequencer
	typedef struct packed {
		snpc_park_type park;
		logic [PORT_COUNT-1:0] ports;
	} snpc_route_type;

endpackage

// File: design/snpc_fifo.sv
// small first-word-fall-through fifo with a registered read port
// assumes producer and consumer share the clock of the instance
`timescale 1ns/1ps
`default_nettype none
module snpc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// the registered output stage holds one word beyond the array, so DEPTH+1 fit
	assign in_ready = count < (AW+1)'(DEPTH);
	assign push = in_valid && in_ready;
	assign pop = (count != '0) && (!out_valid || out_ready);

	// storage array, no reset needed on data
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// registered head word
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data <= mem[rd_ptr];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule // snpc_fifo
`default_nettype wire

// File: design/snpc_port_network.sv
// local scan port network configuration: group register, mode registers,
// chain routing, local clock gating and counter status
// assumes a test controller on CLK that supplies phase strobes and decodes
//
// Contract
// - group codes map to addresses 3C to 3F
// - select only on matching group address
// - mode register zero loads 01 on reset
// - bits 0-2 add ports ascending, padded
// - unpark applies mode port selection
// - parked or none set: register only
// - bit 3 stops idle/pause parked clocks
// - reset-parked clocks stop after 512 pulses
// - bit 7 read-only counter terminal status
// - bit 7 cleared on counter load
// - bits 5 and 6 unused here
// - second mode register resets zero, unused
// - group register resets to 00
// - terminal count holds parked clocks low
// - mode select puts mode register in chain
`timescale 1ns/1ps
`default_nettype none
module snpc_port_network (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// test controller
	input wire logic TLR,
	input wire snpc_pkg::snpc_dr_type DR,
	input wire snpc_pkg::snpc_instr_type INSTR,
	input wire logic UNPARK,
	input wire logic PARK,
	input wire snpc_pkg::snpc_park_type PARK_KIND,
	// tck counter
	input wire logic COUNTER_LOAD,
	input wire logic COUNTER_ON,
	input wire logic COUNTER_ZERO,
	// addressing
	input wire logic ADDR_CHECK,
	input wire logic [7:0] ADDR,
	output logic SELECTED,
	// scan data
	input wire logic TDI_B,
	input wire logic REG_TDO,
	input wire logic [snpc_pkg::PORT_COUNT-1:0] PORT_TDI,
	output logic [snpc_pkg::PORT_COUNT-1:0] PORT_TDO,
	output logic TDO_B,
	// local clocks and status
	output logic [snpc_pkg::PORT_COUNT-1:0] PORT_CLK_EN,
	output logic [7:0] MODE_ZERO,
	output logic ROUTE_BUSY,
	// routing stream to the local port sequencer
	output logic ROUTE_VALID,
	input wire logic ROUTE_READY,
	output snpc_pkg::snpc_route_type ROUTE_DATA
);
	import snpc_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0] mode_reg_zero;
	logic [7:0] mode_reg_one;
	logic [1:0] group_select_register;
	logic counter_status;
	logic [7:0] shift_reg;
	snpc_park_type park_state;
	logic [PORT_COUNT-1:0] active_ports;
	logic [PORT_COUNT-1:0] eff_ports;
	logic [9:0] reset_count;
	logic [9:0] next_reset_count;
	logic [PORT_COUNT-1:0] pad;
	logic [PORT_COUNT:0] chain;
	logic counter_gate;
	logic any_sel;
	logic fifo_ready;
	logic route_push;
	snpc_route_type next_route;
	logic park_take;
	logic unpark_take;

	// group address for a group code
	function automatic logic [7:0] group_address(input logic [1:0] code);
		group_address = GROUP_BASE_ADDR | {6'h00, code};
	endfunction

	assign any_sel = INSTR.mode_select_instr || INSTR.mode_one_select || INSTR.group_select;
	assign counter_gate = COUNTER_ON && COUNTER_ZERO;

	// ------------------------------------------------------------
	// data register shifter
	// ------------------------------------------------------------
	// one shifter serves all three registers; only one is selected at a time
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			shift_reg <= '0;
		end else if (DR.capture && INSTR.mode_select_instr) begin
			shift_reg <= MODE_ZERO;
		end else if (DR.capture && INSTR.mode_one_select) begin
			shift_reg <= mode_reg_one;
		end else if (DR.capture && INSTR.group_select) begin
			shift_reg <= {6'h00, group_select_register};
		end else if (DR.shift && INSTR.group_select) begin
			shift_reg <= {6'h00, TDI_B, shift_reg[1]};
		end else if (DR.shift && any_sel) begin
			shift_reg <= {TDI_B, shift_reg[7:1]};
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// test-logic-reset wins over a coincident update
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			mode_reg_zero <= MODE_ZERO_RESET;
		end else if (TLR) begin
			mode_reg_zero <= MODE_ZERO_RESET;
		end else if (DR.update && INSTR.mode_select_instr) begin
			mode_reg_zero <= shift_reg & MODE_ZERO_WMASK;
		end
	end

	// second mode register kept for the map; it steers nothing on three ports
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			mode_reg_one <= MODE_ONE_RESET;
		end else if (TLR) begin
			mode_reg_one <= MODE_ONE_RESET;
		end else if (DR.update && INSTR.mode_one_select) begin
			mode_reg_one <= shift_reg & MODE_ONE_WMASK;
		end
	end

	// group register
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			group_select_register <= GROUP_RESET;
		end else if (TLR) begin
			group_select_register <= GROUP_RESET;
		end else if (DR.update && INSTR.group_select) begin
			group_select_register <= shift_reg[1:0];
		end
	end

	// counter status: a set in the same cycle as a load wins
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			counter_status <= 1'b0;
		end else if (counter_gate) begin
			counter_status <= 1'b1;
		end else if (COUNTER_LOAD) begin
			counter_status <= 1'b0;
		end
	end

	// read view: status in bit 7, stored bits below
	assign MODE_ZERO = {counter_status, mode_reg_zero[6:0]};

	// ------------------------------------------------------------
	// group addressing
	// ------------------------------------------------------------
	// individual and broadcast addresses are decoded elsewhere
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			SELECTED <= 1'b0;
		end else if (TLR) begin
			SELECTED <= 1'b0;
		end else if (ADDR_CHECK && (ADDR & GROUP_ADDR_MASK) == GROUP_BASE_ADDR) begin
			SELECTED <= (ADDR == group_address(group_select_register));
		end
	end

	// ------------------------------------------------------------
	// park state and applied routing
	// ------------------------------------------------------------
	// a full routing queue refuses park changes so the sequencer never misses one
	assign park_take = PARK && fifo_ready && !TLR;
	assign unpark_take = UNPARK && fifo_ready && !TLR && !PARK;
	assign ROUTE_BUSY = !fifo_ready;

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			park_state <= SNPC_PARKED_IN_RESET;
			active_ports <= '0;
		end else if (TLR) begin
			park_state <= SNPC_PARKED_IN_RESET;
			active_ports <= '0;
		end else if (park_take) begin
			park_state <= PARK_KIND;
			active_ports <= '0;
		end else if (unpark_take) begin
			park_state <= SNPC_UNPARKED;
			active_ports <= mode_reg_zero[MODE_PORT_LSB +: PORT_COUNT];
		end
	end

	// parked network or empty selection leaves only the register
	assign eff_ports = (park_state == SNPC_UNPARKED) ? active_ports : '0;

	// ------------------------------------------------------------
	// scan chain
	// ------------------------------------------------------------
	assign chain[0] = any_sel ? shift_reg[0] : REG_TDO;

	// each included port in ascending order, then its pad stage
	generate
		for (genvar i = 0; i < PORT_COUNT; i++) begin : g_port
			always_ff @(posedge CLK or posedge RESET) begin
				if (RESET) begin
					pad[i] <= 1'b0;
				end else begin
					pad[i] <= PORT_TDI[i];
				end
			end
			assign PORT_TDO[i] = chain[i];
			assign chain[i+1] = eff_ports[i] ? pad[i] : chain[i];
		end
	endgenerate

	assign TDO_B = chain[PORT_COUNT];

	// ------------------------------------------------------------
	// local clock gating
	// ------------------------------------------------------------
	// counts backplane pulses since entry into the reset park, saturating
	always_comb begin
		next_reset_count = reset_count;
		if (park_state != SNPC_PARKED_IN_RESET || TLR) begin
			next_reset_count = '0;
		end else if (reset_count < RESET_PARK_CYCLES) begin
			next_reset_count = reset_count + 10'd1;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			reset_count <= '0;
		end else begin
			reset_count <= next_reset_count;
		end
	end

	// enables are registered so the local clock gate sees a clean level
	generate
		for (genvar i = 0; i < PORT_COUNT; i++) begin : g_clk
			always_ff @(posedge CLK or posedge RESET) begin
				if (RESET) begin
					PORT_CLK_EN[i] <= 1'b1;
				end else if (eff_ports[i]) begin
					PORT_CLK_EN[i] <= 1'b1;
				end else if (counter_gate) begin
					PORT_CLK_EN[i] <= 1'b0;
				end else if (park_state == SNPC_PARKED_IN_RESET) begin
					PORT_CLK_EN[i] <= next_reset_count < RESET_PARK_CYCLES;
				end else begin
					PORT_CLK_EN[i] <= !mode_reg_zero[MODE_CLK_STOP_BIT];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// routing stream
	// ------------------------------------------------------------
	assign route_push = park_take || unpark_take;
	assign next_route.park = unpark_take ? SNPC_UNPARKED : PARK_KIND;
	assign next_route.ports = unpark_take ? mode_reg_zero[MODE_PORT_LSB +: PORT_COUNT] : '0;

	snpc_fifo #(
		.WIDTH($bits(snpc_route_type)),
		.DEPTH(FIFO_DEPTH)
	) u_route_fifo (
		.clk(CLK),
		.reset(RESET),
		.in_valid(route_push),
		.in_ready(fifo_ready),
		.in_data(next_route),
		.out_valid(ROUTE_VALID),
		.out_ready(ROUTE_READY),
		.out_data(ROUTE_DATA)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	a_tlr_mode_load: assert property (TLR |=> mode_reg_zero == 8'h01)
		else $error("mode register zero not 01 after reset state");
	a_tlr_group_clear: assert property (TLR |=> group_select_register == 2'h0)
		else $error("group register not cleared by reset state");
	a_group_match: assert property (ADDR_CHECK && !TLR && ADDR[7:2] == 6'h0f
		|=> SELECTED == ($past(ADDR[1:0]) == $past(group_select_register)))
		else $error("group selection disagrees with group register");
	a_status_set: assert property (COUNTER_ON && COUNTER_ZERO |=> MODE_ZERO[7])
		else $error("counter status not set at terminal count");
	a_status_clear: assert property (COUNTER_LOAD && !counter_gate
		|=> !MODE_ZERO[7])
		else $error("counter status not cleared by load");
	a_status_held: assert property (!counter_gate && !MODE_ZERO[7] |=> !MODE_ZERO[7])
		else $error("counter status set without terminal count");
	a_high_bits_zero: assert property (mode_reg_zero[6:5] == 2'b00)
		else $error("unused mode bits hold a value");
	a_unpark_apply: assert property (UNPARK && fifo_ready && !TLR && !PARK
		|=> eff_ports == $past(mode_reg_zero[2:0]))
		else $error("unpark did not apply mode port bits");
	a_parked_route: assert property (park_state != SNPC_UNPARKED |-> TDO_B == chain[0])
		else $error("parked network passes through a port");
	a_chain_last: assert property (eff_ports[2] |-> TDO_B == pad[2])
		else $error("last included port not at backplane output");
	a_idle_stop: assert property (park_state == SNPC_PARKED_IN_IDLE
		&& mode_reg_zero[3] |=> !PORT_CLK_EN[0])
		else $error("idle parked clock runs with stop bit set");
	a_counter_hold: assert property (counter_gate && !eff_ports[1] |=> !PORT_CLK_EN[1])
		else $error("terminal count did not stop parked clock");
	a_reset_gate: assert property (park_state == SNPC_PARKED_IN_RESET
		&& reset_count == RESET_PARK_CYCLES |-> !PORT_CLK_EN[2])
		else $error("reset parked clock not stopped after 512 pulses");
	a_reset_run: assert property (park_state == SNPC_PARKED_IN_RESET
		&& reset_count < 10'd511 && !counter_gate |=> PORT_CLK_EN[2])
		else $error("reset parked clock stopped too early");

	c_unpark_all: cover property (UNPARK && fifo_ready && mode_reg_zero[2:0] == 3'h7);
	c_group_hit: cover property (ADDR_CHECK ##1 SELECTED);
	c_queue_full: cover property (ROUTE_BUSY && UNPARK);
	c_reset_stop: cover property (reset_count == 10'd512);
endmodule // snpc_port_network
`default_nettype wire

// File: bench/snpc_port_model.sv
// local scan port model: one bypass stage per port and a route consumer
// assumes it shares the clock and reset of the network block
`timescale 1ns/1ps
`default_nettype none
module snpc_port_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// scan data
	input wire logic [snpc_pkg::PORT_COUNT-1:0] port_tdo,
	output logic [snpc_pkg::PORT_COUNT-1:0] port_tdi,
	// routing stream and its bench controls
	input wire logic route_valid,
	output logic route_ready,
	input wire snpc_pkg::snpc_route_type route_data,
	input wire logic stall,
	output int taken,
	output snpc_pkg::snpc_route_type last
);
	import snpc_pkg::*;
	// ---------------------------------------------------------------
	// local devices sit in bypass: one clock of delay per port
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			port_tdi <= '0;
		end else begin
			port_tdi <= port_tdo;
		end
	end
	// stalling the sequencer lets the queue in front of it fill up
	assign route_ready = !stall;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			taken <= 0;
			last <= '0;
		end else if (route_valid && route_ready) begin
			taken <= taken + 1;
			last <= route_data;
		end
	end
endmodule // snpc_port_model
`default_nettype wire

// File: bench/tb_top.sv
// testbench for the scan port network block
// assumes the package, the design modules and the port model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import snpc_pkg::*;
	logic clk, reset, tlr, unpark, park, c_load, c_on, c_zero, a_chk, tdi_b, reg_tdo;
	logic selected, tdo_b, busy, r_valid, r_ready, stall;
	logic [7:0] addr, mode_zero, rv;
	logic [2:0] p_tdi, p_tdo, clk_en;
	snpc_dr_type dr;
	snpc_instr_type instr;
	snpc_park_type kind;
	snpc_route_type r_data, last;
	int errors, n_tests, taken, k, lat, t0;

	snpc_port_network uut (.CLK(clk), .RESET(reset), .TLR(tlr), .DR(dr), .INSTR(instr),
		.UNPARK(unpark), .PARK(park), .PARK_KIND(kind), .COUNTER_LOAD(c_load),
		.COUNTER_ON(c_on), .COUNTER_ZERO(c_zero), .ADDR_CHECK(a_chk), .ADDR(addr),
		.SELECTED(selected), .TDI_B(tdi_b), .REG_TDO(reg_tdo), .PORT_TDI(p_tdi),
		.PORT_TDO(p_tdo), .TDO_B(tdo_b), .PORT_CLK_EN(clk_en), .MODE_ZERO(mode_zero),
		.ROUTE_BUSY(busy), .ROUTE_VALID(r_valid), .ROUTE_READY(r_ready), .ROUTE_DATA(r_data));
	snpc_port_model ports (.clk(clk), .reset(reset), .port_tdo(p_tdo), .port_tdi(p_tdi),
		.route_valid(r_valid), .route_ready(r_ready), .route_data(r_data), .stall(stall),
		.taken(taken), .last(last));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// one data scan: capture, n shifts lsb first (old value lands in rv), update
	task automatic scan(input int sel, input int n, input logic [7:0] wv);
		int i;
		rv = '0;
		instr = '0;
		instr[sel] = 1'b1;
		dr = 3'b100;
		cyc(1);
		dr = 3'b010;
		for (i = 0; i < n; i++) begin
			tdi_b = wv[i];
			#1 rv[i] = tdo_b;
			cyc(1);
		end
		dr = 3'b001;
		cyc(1);
		dr = '0;
		instr = '0;
	endtask
	task automatic do_park(input snpc_park_type pk);
		kind = pk;
		park = 1'b1;
		cyc(1);
		park = 1'b0;
		cyc(2);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// a hang is cut short well beyond the fewer than one thousand cycles the run needs
	initial begin
		#100000;
		errors++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{reset, tlr, unpark, park, c_load, c_on, c_zero, a_chk, tdi_b, reg_tdo} = 10'h200;
		{stall, addr, dr, instr, errors, n_tests} = '0;
		kind = SNPC_UNPARKED;
		cyc(5);
		reset = 1'b0;
		cyc(1);
		// register reset values and writable bits, read back through scans and the MODE_ZERO view
		scan(2, 8, 8'hff);
		chk(rv, MODE_ZERO_RESET);
		chk(mode_zero, 8'h1f);
		scan(1, 8, 8'h5a);
		chk(rv, 8'h00);
		scan(1, 8, 8'h00);
		chk(rv, 8'h5a);
		// master programs the group code before addressing, every code tried
		for (int g = 0; g < 4; g++) begin
			scan(0, 2, 8'(g));
			for (int a = 0; a < 4; a++) begin
				addr = GROUP_BASE_ADDR + 8'(a);
				a_chk = 1'b1;
				cyc(1);
				a_chk = 1'b0;
				chk(8'(selected), 8'(a == g));
			end
		end
		// an address outside the group range leaves the selection alone
		addr = 8'h3b;
		a_chk = 1'b1;
		cyc(1);
		a_chk = 1'b0;
		chk(8'(selected), 8'h01);
		tlr = 1'b1;
		cyc(1);
		tlr = 1'b0;
		chk(8'(selected), 8'h00);
		chk(mode_zero, MODE_ZERO_RESET);
		addr = 8'h3c;
		a_chk = 1'b1;
		cyc(1);
		a_chk = 1'b0;
		chk(8'(selected), 8'h01);
		// every port selection: clocks, route word and chain length
		for (int m = 0; m < 8; m++) begin
			do_park(SNPC_PARKED_IN_IDLE);
			scan(2, 8, 8'(m) | 8'h08);
			unpark = 1'b1;
			cyc(1);
			unpark = 1'b0;
			cyc(8);
			chk(8'(clk_en), 8'(m));
			chk(8'(last.ports), 8'(m));
			reg_tdo = 1'b1;
			lat = -1;
			for (int i = 0; i < 8; i++) begin
				#1 if (tdo_b === 1'b1 && lat < 0) lat = i;
				cyc(1);
				reg_tdo = 1'b0;
			end
			chk(8'(lat), 8'(2 * $countones(m)));
		end
		// parked with all ports chosen: only the internal register remains
		do_park(SNPC_PARKED_IN_IDLE);
		scan(2, 8, 8'h07);
		cyc(2);
		chk(8'(clk_en), 8'h07);
		reg_tdo = 1'b1;
		#1 chk(8'(tdo_b), 8'h01);
		cyc(1);
		reg_tdo = 1'b0;
		#1 chk(8'(tdo_b), 8'h00);
		cyc(1);
		// terminal count gates parked clocks and sets the sticky status
		c_on = 1'b1;
		c_zero = 1'b1;
		cyc(2);
		chk(8'(clk_en), 8'h00);
		scan(2, 8, 8'h07);
		chk(8'(rv[7]), 8'h01);
		c_on = 1'b0;
		cyc(2);
		chk(8'(clk_en), 8'h07);
		chk(8'(mode_zero[7]), 8'h01);
		c_zero = 1'b0;
		c_load = 1'b1;
		cyc(1);
		c_load = 1'b0;
		cyc(1);
		chk(8'(mode_zero[7]), 8'h00);
		// reset-parked ports lose their clocks after 512 pulses
		do_park(SNPC_PARKED_IN_RESET);
		cyc(509);
		chk(8'(clk_en), 8'h07);
		cyc(1);
		chk(8'(clk_en), 8'h00);
		// stalled sequencer: the queue fills, refuses, then drains whole
		stall = 1'b1;
		t0 = taken;
		k = 0;
		unpark = 1'b1;
		for (int i = 0; i < 24; i++) begin
			if (busy === 1'b0) k++;
			cyc(1);
		end
		unpark = 1'b0;
		chk(8'(busy), 8'h01);
		chk(8'(k), 8'd17);
		stall = 1'b0;
		cyc(30);
		chk(8'(busy), 8'h00);
		chk(8'(taken - t0), 8'd17);
		chk(8'(last.ports), 8'h07);
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
